// [dso_pkg.sv]
// package: register map, field positions, reset values and carriers of the sync output block
// Behaviour
// - panel vsync polarity picks idle and pulse levels
// - panel hsync polarity picks idle and pulse levels
// - crt_vert_sync_pin polarity inverts both levels when set
// - crt_horiz_sync_pin polarity inverts both levels when set
// - blink enable blinks cursor and pixels, rate-selected
// - vertical irq enable raises irq at next vsync
// - writing enable zero disables and clears pending
// - generator enabled: timing runs, timing writes rejected
// - generator disabled: timing writable, dot logic reset
// - ddc clock bit drives crt_vert_sync_pin while disabled
// - blank enable gates display enable output low
// - hsync enable zero holds crt_horiz_sync_pin low
// - hsync enable touches crt only, not panel
// - vsync enable zero hands crt_vert_sync_pin to the ddc clock bit
// - ddc input status reads ddc data pin
package dso_pkg;

  // register byte addresses on the bus
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h08;
  localparam logic [7:0] ADDR_H_TIMING = 8'h0c;
  localparam logic [7:0] ADDR_V_TIMING = 8'h10;

  // display_timing_config fields
  localparam int unsigned BIT_VERT_PENDING = 31;
  localparam int unsigned BIT_VERT_NOT_ACTIVE = 30;
  localparam int unsigned BIT_DISP_NOT_ACTIVE = 29;
  localparam int unsigned BIT_DDC_INPUT = 27;
  localparam int unsigned BIT_BLINK_RATE = 16;
  localparam int unsigned BIT_PANEL_VPOL = 11;
  localparam int unsigned BIT_PANEL_HPOL = 10;
  localparam int unsigned BIT_CRT_VPOL = 9;
  localparam int unsigned BIT_CRT_HPOL = 8;
  localparam int unsigned BIT_BLINK_EN = 7;
  localparam int unsigned BIT_VIRQ_EN = 6;
  localparam int unsigned BIT_TIMING_GEN_ENABLE = 5;
  localparam int unsigned BIT_DDC_CLK = 4;
  localparam int unsigned BIT_BLANK_EN = 3;
  localparam int unsigned BIT_HSYNC_EN = 2;
  localparam int unsigned BIT_VSYNC_EN = 1;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WR_MASK = 32'h0001_0ffe;

  // interrupt status and mask layout
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_VERT = 0;
  localparam int unsigned IRQ_REJECT = 1;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

  // timing register resets: blank_len[27:20] sync_len[19:12] total[11:0]
  localparam logic [31:0] H_TIMING_RESET = 32'h0301_031f;
  localparam logic [31:0] V_TIMING_RESET = 32'h0200_220c;
  localparam logic [31:0] TIMING_WR_MASK = 32'h0fff_ffff;

  // dot clock enable every DOT_DIV system clocks
  localparam logic [1:0] DOT_DIV = 2'h2;
  // frames per blink phase
  localparam logic [5:0] BLINK_FRAMES_FAST = 6'h10;
  localparam logic [5:0] BLINK_FRAMES_SLOW = 6'h20;

  typedef struct packed {
    logic [7:0] blank_len;
    logic [7:0] sync_len;
    logic [11:0] total;
  } dso_timing_s;

  typedef struct packed {
    logic hsync;
    logic vsync;
    logic h_active;
    logic v_active;
  } dso_sync_s;

endpackage

// [dso_timing.sv]
// dot-clock timing generator producing active-high sync pulses and active flags
`timescale 1ns/1ps
module dso_timing
  import dso_pkg::*;
(
  // clock and combined reset
  input wire logic clk_i,
  input wire logic reset_i,
  // dot clock enable pulse
  input wire logic dot_en_i,
  // timing setup
  input wire dso_timing_s h_cfg_i,
  input wire dso_timing_s v_cfg_i,
  // internal sync
  output dso_sync_s sync_o
);

  logic [11:0] h_cnt_q;
  logic [11:0] v_cnt_q;
  logic h_wrap;
  logic v_wrap;

  assign h_wrap = (h_cnt_q >= h_cfg_i.total);
  assign v_wrap = (v_cnt_q >= v_cfg_i.total);

  // held in reset while the generator is disabled
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      h_cnt_q <= 12'h000;
    end else if (dot_en_i) begin
      h_cnt_q <= h_wrap ? 12'h000 : h_cnt_q + 12'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      v_cnt_q <= 12'h000;
    end else if (dot_en_i && h_wrap) begin
      v_cnt_q <= v_wrap ? 12'h000 : v_cnt_q + 12'h001;
    end
  end

  always_comb begin
    sync_o.hsync = ~reset_i & (h_cnt_q < {4'h0, h_cfg_i.sync_len});
    sync_o.vsync = ~reset_i & (v_cnt_q < {4'h0, v_cfg_i.sync_len});
    sync_o.h_active = ~reset_i & (h_cnt_q >= {4'h0, h_cfg_i.blank_len});
    sync_o.v_active = ~reset_i & (v_cnt_q >= {4'h0, v_cfg_i.blank_len});
  end

endmodule

// [dso_top.sv]
// sync output control: configuration register, wishbone slave, sync shaping, irq and blink
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module dso_top
  import dso_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // panel power sequencing and ddc
  input wire logic panel_seq_enable_i,
  input wire logic ddc_data_in_pin_i,
  // crt outputs
  output logic crt_horiz_sync_pin_o,
  output logic crt_vert_sync_pin_o,
  // panel outputs
  output logic panel_hsync_o,
  output logic panel_vsync_o,
  output logic display_enable_out_o,
  // blink and interrupt
  output logic blink_visible_o,
  output logic irq_o
);

  // polarity first, enable last, so a disabled output is low whatever the polarity
  function automatic logic shape_sync(input logic pulse, input logic pol, input logic en);
    shape_sync = en & (pulse ^ pol);
  endfunction

  function automatic logic [31:0] byte_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    byte_merge = res;
  endfunction

  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] cfg_q;
  logic [31:0] h_tim_q;
  logic [31:0] v_tim_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic vert_pending_q;
  logic [1:0] dot_div_q;
  logic vs_prev_q;
  logic [5:0] frame_cnt_q;
  logic blink_phase_q;
  logic crt_h_q;
  logic crt_v_q;
  logic panel_h_q;
  logic panel_v_q;
  logic disp_en_q;
  logic blink_vis_q;
  logic irq_q;

  logic req;
  logic wr;
  logic cfg_wr;
  logic tim_wr;
  logic reject;
  logic timing_gen_enable;
  logic dot_rst;
  logic dot_en;
  logic vert_event;
  logic vert_clear;
  logic [5:0] blink_limit;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] rd_data;
  dso_sync_s sync;

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign cfg_wr = wr & (wb_adr_i == ADDR_CFG);
  assign tim_wr = wr & ((wb_adr_i == ADDR_H_TIMING) | (wb_adr_i == ADDR_V_TIMING));
  assign timing_gen_enable = cfg_q[BIT_TIMING_GEN_ENABLE];
  assign reject = tim_wr & timing_gen_enable;
  assign dot_rst = reset_i | ~timing_gen_enable;
  assign dot_en = (dot_div_q == DOT_DIV - 2'h1);

  // bus slave: one wait-free answer, ack the cycle after the request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      dat_q <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      dat_q <= rd_data;
    end
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_CFG: begin
        rd_data = cfg_q;
        rd_data[BIT_VERT_PENDING] = vert_pending_q;
        rd_data[BIT_VERT_NOT_ACTIVE] = ~sync.v_active;
        rd_data[BIT_DISP_NOT_ACTIVE] = ~(sync.h_active & sync.v_active);
        rd_data[BIT_DDC_INPUT] = ddc_data_in_pin_i;
      end
      ADDR_IRQ_STAT: rd_data[IRQ_W-1:0] = irq_stat_q;
      ADDR_IRQ_MASK: rd_data[IRQ_W-1:0] = irq_mask_q;
      ADDR_H_TIMING: rd_data = h_tim_q;
      ADDR_V_TIMING: rd_data = v_tim_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  // configuration register; status bits above are not stored
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_q <= CFG_RESET;
    end else if (cfg_wr) begin
      cfg_q <= byte_merge(cfg_q, wb_dat_i, wb_sel_i) & CFG_WR_MASK;
    end
  end

  // timing registers are locked while the generator runs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      h_tim_q <= H_TIMING_RESET;
    end else if (wr && wb_adr_i == ADDR_H_TIMING && !timing_gen_enable) begin
      h_tim_q <= byte_merge(h_tim_q, wb_dat_i, wb_sel_i) & TIMING_WR_MASK;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      v_tim_q <= V_TIMING_RESET;
    end else if (wr && wb_adr_i == ADDR_V_TIMING && !timing_gen_enable) begin
      v_tim_q <= byte_merge(v_tim_q, wb_dat_i, wb_sel_i) & TIMING_WR_MASK;
    end
  end

  // dot clock enable divider, itself dot-clock logic
  always_ff @(posedge clk_i) begin
    if (dot_rst) begin
      dot_div_q <= 2'h0;
    end else begin
      dot_div_q <= dot_en ? 2'h0 : dot_div_q + 2'h1;
    end
  end

  dso_timing u_timing (
    .clk_i(clk_i),
    .reset_i(dot_rst),
    .dot_en_i(dot_en),
    .h_cfg_i(dso_timing_s'(h_tim_q[27:0])),
    .v_cfg_i(dso_timing_s'(v_tim_q[27:0])),
    .sync_o(sync)
  );

  always_ff @(posedge clk_i) begin
    if (dot_rst) begin
      vs_prev_q <= 1'b0;
    end else begin
      vs_prev_q <= sync.vsync;
    end
  end

  assign vert_event = sync.vsync & ~vs_prev_q;
  assign vert_clear = cfg_wr & wb_sel_i[0] & ~wb_dat_i[BIT_VIRQ_EN];

  // clear wins here: a disabling write must leave nothing pending
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      vert_pending_q <= 1'b0;
    end else if (vert_clear) begin
      vert_pending_q <= 1'b0;
    end else if (vert_event && cfg_q[BIT_VIRQ_EN]) begin
      vert_pending_q <= 1'b1;
    end
  end

  // sticky status, write one to clear, a new event beats the clear
  always_comb begin
    irq_set = IRQ_RESET;
    irq_set[IRQ_VERT] = vert_event & cfg_q[BIT_VIRQ_EN] & ~vert_clear;
    irq_set[IRQ_REJECT] = reject;
    irq_clr = IRQ_RESET;
    if (wr && wb_adr_i == ADDR_IRQ_STAT && wb_sel_i[0]) begin
      irq_clr = wb_dat_i[IRQ_W-1:0];
    end
    if (vert_clear) begin
      irq_clr[IRQ_VERT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_stat_q <= IRQ_RESET;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_mask_q <= IRQ_RESET;
    end else if (wr && wb_adr_i == ADDR_IRQ_MASK && wb_sel_i[0]) begin
      irq_mask_q <= wb_dat_i[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // blink phase counts frames; the rate bit picks fast or slow
  assign blink_limit = cfg_q[BIT_BLINK_RATE] ? BLINK_FRAMES_SLOW : BLINK_FRAMES_FAST;

  always_ff @(posedge clk_i) begin
    if (dot_rst) begin
      frame_cnt_q <= 6'h00;
      blink_phase_q <= 1'b1;
    end else if (vert_event) begin
      if (frame_cnt_q >= blink_limit - 6'h01) begin
        frame_cnt_q <= 6'h00;
        blink_phase_q <= ~blink_phase_q;
      end else begin
        frame_cnt_q <= frame_cnt_q + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      blink_vis_q <= 1'b1;
    end else begin
      blink_vis_q <= ~cfg_q[BIT_BLINK_EN] | blink_phase_q;
    end
  end

  // sync pin shaping, registered so the pins never glitch
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      crt_h_q <= 1'b0;
    end else begin
      crt_h_q <= shape_sync(sync.hsync, cfg_q[BIT_CRT_HPOL], cfg_q[BIT_HSYNC_EN]);
    end
  end

  // with vsync disabled the pin carries the ddc clock bit, low while that bit is low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      crt_v_q <= 1'b0;
    end else if (cfg_q[BIT_VSYNC_EN]) begin
      crt_v_q <= shape_sync(sync.vsync, cfg_q[BIT_CRT_VPOL], 1'b1);
    end else begin
      crt_v_q <= cfg_q[BIT_DDC_CLK];
    end
  end

  // panel syncs follow the power sequencer, never the crt enables
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      panel_h_q <= 1'b0;
      panel_v_q <= 1'b0;
    end else begin
      panel_h_q <= shape_sync(sync.hsync, cfg_q[BIT_PANEL_HPOL], panel_seq_enable_i);
      panel_v_q <= shape_sync(sync.vsync, cfg_q[BIT_PANEL_VPOL], panel_seq_enable_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      disp_en_q <= 1'b0;
    end else begin
      disp_en_q <= cfg_q[BIT_BLANK_EN] & sync.h_active & sync.v_active;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign crt_horiz_sync_pin_o = crt_h_q;
  assign crt_vert_sync_pin_o = crt_v_q;
  assign panel_hsync_o = panel_h_q;
  assign panel_vsync_o = panel_v_q;
  assign display_enable_out_o = disp_en_q;
  assign blink_visible_o = blink_vis_q;
  assign irq_o = irq_q;

endmodule

// [dso_chk.sv]
// port-level assertions for the sync output block, bound to dso_top
`timescale 1ns/1ps
module dso_chk
  import dso_pkg::*;
(
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic panel_seq_enable_i,
  input wire logic ddc_data_in_pin_i,
  input wire logic crt_horiz_sync_pin_o,
  input wire logic crt_vert_sync_pin_o,
  input wire logic panel_hsync_o,
  input wire logic panel_vsync_o,
  input wire logic display_enable_out_o
);
  logic [31:0] cfg_q;
  logic taken;
  assign taken = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // shadow of the config register, rebuilt from taken bus writes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_q <= CFG_RESET;
    end else if (taken && wb_we_i && wb_adr_i == ADDR_CFG) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) cfg_q[8*i+:8] <= wb_dat_i[8*i+:8] & CFG_WR_MASK[8*i+:8];
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_rd_cfg;
    taken && !wb_we_i && wb_adr_i == ADDR_CFG;
  endsequence
  // generator off long enough for its reset to reach the pins
  sequence s_gen_off;
    (!cfg_q[BIT_TIMING_GEN_ENABLE]) [*4];
  endsequence
  property p_hsync_off;
    !cfg_q[BIT_HSYNC_EN] |=> !crt_horiz_sync_pin_o;
  endproperty
  a_hsync_off: assert property (p_hsync_off)
    else $error("crt_horiz_sync_pin not low");
  property p_ddc_clock;
    !cfg_q[BIT_VSYNC_EN] |=> crt_vert_sync_pin_o == $past(cfg_q[BIT_DDC_CLK]);
  endproperty
  a_ddc_clock: assert property (p_ddc_clock)
    else $error("crt_vert_sync_pin not ddc clock");
  property p_blank_off;
    !cfg_q[BIT_BLANK_EN] |=> !display_enable_out_o;
  endproperty
  a_blank_off: assert property (p_blank_off)
    else $error("display enable not low");
  property p_crt_h_idle;
    s_gen_off |=> crt_horiz_sync_pin_o == $past(cfg_q[BIT_HSYNC_EN] & cfg_q[BIT_CRT_HPOL]);
  endproperty
  a_crt_h_idle: assert property (p_crt_h_idle)
    else $error("crt_horiz_sync_pin idle level");
  property p_crt_v_idle;
    s_gen_off ##0 cfg_q[BIT_VSYNC_EN] |=> crt_vert_sync_pin_o == $past(cfg_q[BIT_CRT_VPOL]);
  endproperty
  a_crt_v_idle: assert property (p_crt_v_idle)
    else $error("crt_vert_sync_pin idle level");
  property p_panel_v;
    s_gen_off |=> panel_vsync_o == $past(panel_seq_enable_i & cfg_q[BIT_PANEL_VPOL]);
  endproperty
  a_panel_v: assert property (p_panel_v)
    else $error("panel vsync idle level");
  property p_panel_h;
    s_gen_off |=> panel_hsync_o == $past(panel_seq_enable_i & cfg_q[BIT_PANEL_HPOL]);
  endproperty
  a_panel_h: assert property (p_panel_h)
    else $error("panel hsync idle level");
  property p_ddc_read;
    s_rd_cfg |=> (wb_ack_o && wb_dat_o[BIT_DDC_INPUT] == $past(ddc_data_in_pin_i)) ##1 !wb_ack_o;
  endproperty
  a_ddc_read: assert property (p_ddc_read)
    else $error("ddc input read");
endmodule

bind dso_top dso_chk u_chk (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .panel_seq_enable_i(panel_seq_enable_i), .ddc_data_in_pin_i(ddc_data_in_pin_i),
  .crt_horiz_sync_pin_o(crt_horiz_sync_pin_o), .crt_vert_sync_pin_o(crt_vert_sync_pin_o),
  .panel_hsync_o(panel_hsync_o), .panel_vsync_o(panel_vsync_o),
  .display_enable_out_o(display_enable_out_o));

// [dso_monitor.sv]
// monitor model: ddc1 data source clocked by crt_vert_sync_pin, hsync pulse width meter
`timescale 1ns/1ps
module dso_monitor #(
  parameter logic [7:0] PAT = 8'ha6
) (
  // clock and sync pins
  input wire logic clk_i,
  input wire logic vsync_i,
  input wire logic hsync_i,
  // ddc data and measured width
  output logic ddc_data_o,
  output logic [7:0] hwidth_o
);
  logic [2:0] idx_q = 3'h0;
  logic v_q = 1'b0;
  logic [7:0] run_q = 8'h00;
  // one writer only: the width register lives here, the port just shows it
  logic [7:0] width_q = 8'h00;
  // next data bit on each rising ddc clock, as a ddc1 monitor does
  always_ff @(posedge clk_i) begin
    v_q <= vsync_i;
    if (vsync_i && !v_q) idx_q <= idx_q + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    if (hsync_i) begin
      run_q <= run_q + 8'h01;
    end else if (run_q != 8'h00) begin
      width_q <= run_q;
      run_q <= 8'h00;
    end
  end
  assign ddc_data_o = PAT[idx_q];
  assign hwidth_o = width_q;
endmodule

// [test_display_sync_output_control.sv]
// self-checking bench for the sync output block
`timescale 1ns/1ps
module test_display_sync_output_control;
  import dso_pkg::*;
  localparam logic [7:0] DDC_PAT = 8'ha6;
  logic clk_i = 1'b0, reset_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, seq = 1'b0, s;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rd, v, dat_o, rng = 32'hce9b588e;
  logic ack, crt_h, crt_v, pan_h, pan_v, de, blink, irq, ddc;
  logic [7:0] hw;
  logic [7:0] ra[5] = '{ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_H_TIMING, ADDR_V_TIMING, 8'h14};
  logic [31:0] rv[5] = '{32'h0, 32'h0, H_TIMING_RESET, V_TIMING_RESET, 32'h0};
  int n_errors = 0, n_tests = 0, c;
  logic [31:0] nde, nv, nh;
  dso_top dut (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .panel_seq_enable_i(seq), .ddc_data_in_pin_i(ddc), .crt_horiz_sync_pin_o(crt_h),
    .crt_vert_sync_pin_o(crt_v), .panel_hsync_o(pan_h), .panel_vsync_o(pan_v),
    .display_enable_out_o(de), .blink_visible_o(blink), .irq_o(irq));
  dso_monitor #(.PAT(DDC_PAT)) mon (.clk_i(clk_i), .vsync_i(crt_v), .hsync_i(crt_h),
    .ddc_data_o(ddc), .hwidth_o(hw));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; waits for ack without assuming a latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) n_errors++;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    fork
      begin
        #500000;
        n_errors++;
        stop_test();
      end
    join_none
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    // ddc1 read-out: vsync enable stays clear, clock bit pulsed high then low
    for (int k = 1; k < 5; k++) begin
      bus(1'b1, ADDR_CFG, 32'h10);
      bus(1'b1, ADDR_CFG, 32'h0);
      bus(1'b0, ADDR_CFG, 32'h0);
      chk("ddc read", rd, {4'h6, DDC_PAT[k], 27'h0});
    end
    chk("blink", {31'h0, blink}, 32'h1);
    foreach (ra[i]) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    $display("test ddc and reset values done");
    for (int k = 0; k < 8; k++) begin
      v = xs();
      s = v[31];
      @(posedge clk_i) seq <= s;
      v &= 32'h0000_0f1e;
      bus(1'b1, ADDR_CFG, v);
      bus(1'b0, ADDR_CFG, 32'h0);
      chk("cfg", rd & 32'hf7ff_ffff, v | 32'h6000_0000);
      chk("pins", {27'h0, crt_h, crt_v, pan_h, pan_v, de}, {27'h0, v[2] & v[8],
        v[1] ? v[9] : v[4], s & v[10], s & v[11], 1'b0});
    end
    $display("test static pin levels done");
    // short frame: 10 dots a line, 5 lines
    bus(1'b1, ADDR_H_TIMING, 32'h0030_2009);
    bus(1'b1, ADDR_V_TIMING, 32'h0020_1004);
    bus(1'b1, ADDR_IRQ_MASK, 32'h3);
    bus(1'b1, ADDR_CFG, 32'hee);
    c = 0;
    while (irq !== 1'b1 && c < 1000) begin
      @(posedge clk_i);
      c++;
    end
    chk("irq raised", {31'h0, irq}, 32'h1);
    // fast rate: phase flips at the 16th vsync, 15 frames of 100 clocks after the first
    c = 0;
    while (blink !== 1'b0 && c < 4000) begin
      @(posedge clk_i);
      c++;
    end
    chk("blink period", {31'h0, c > 1450 && c < 1550}, 32'h1);
    // the first hsync merges with the old static level, so width is read late
    chk("hsync width", {24'h0, hw}, 32'h4);
    nde = 32'h0;
    nv = 32'h0;
    nh = 32'h0;
    // any 100-clock window is one whole frame of the short timing
    repeat (100) begin
      @(posedge clk_i);
      nde += de;
      nv += crt_v;
      nh += crt_h;
    end
    chk("active clocks", nde, 32'h2a);
    chk("vsync high clocks", nv, 32'h14);
    chk("hsync high clocks", nh, 32'h14);
    bus(1'b1, ADDR_H_TIMING, 32'h0);
    bus(1'b0, ADDR_H_TIMING, 32'h0);
    chk("locked timing", rd, 32'h0030_2009);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("status", rd, 32'h3);
    bus(1'b1, ADDR_CFG, 32'h2e);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("status after disable", rd, 32'h2);
    bus(1'b1, ADDR_IRQ_STAT, 32'h2);
    bus(1'b0, ADDR_IRQ_STAT, 32'h0);
    chk("status cleared", rd, 32'h0);
    chk("irq low", {31'h0, irq}, 32'h0);
    bus(1'b1, ADDR_CFG, 32'h0);
    $display("test running timing and irq done");
    stop_test();
  end
endmodule
